/* logic/cdfc_pkg.sv */
// cdfc_pkg: constants and types of the frame discard statistics block
// assumes one clock domain and a byte-wide register port

package cdfc_pkg;

    // ------------------------
    // register port geometry
    // ------------------------
    localparam int unsigned CDFC_AW = 10;
    localparam int unsigned CDFC_DW = 8;
    localparam int unsigned CDFC_EW = 6;

    // ------------------------
    // register offsets
    // ------------------------
    localparam logic [9:0] CDFC_UART_DROP_OFS  = 10'h265;
    localparam logic [9:0] CDFC_LOWER_DROP_OFS = 10'h266;
    localparam logic [9:0] CDFC_UPPER_DROP_OFS = 10'h267;
    localparam logic [9:0] CDFC_IRQ_STAT_OFS   = 10'h270;
    localparam logic [9:0] CDFC_IRQ_MASK_OFS   = 10'h271;

    // ------------------------
    // reset values and limits
    // ------------------------
    localparam logic [7:0] CDFC_COUNT_RST  = 8'h00;
    localparam logic [7:0] CDFC_COUNT_ONE  = 8'h01;
    localparam logic [7:0] CDFC_COUNT_MAX  = 8'hff;
    localparam logic [7:0] CDFC_COUNT_NEAR = 8'hfe;
    localparam logic [7:0] CDFC_RDATA_RST  = 8'h00;
    localparam logic [5:0] CDFC_STAT_RST   = 6'h00;
    localparam logic [5:0] CDFC_MASK_RST   = 6'h00;

    // ------------------------
    // event bit positions in status and mask
    // ------------------------
    localparam int unsigned CDFC_EVT_UART_DROP  = 0;
    localparam int unsigned CDFC_EVT_LOWER_DROP = 1;
    localparam int unsigned CDFC_EVT_UPPER_DROP = 2;
    localparam int unsigned CDFC_EVT_UART_SAT   = 3;
    localparam int unsigned CDFC_EVT_LOWER_SAT  = 4;
    localparam int unsigned CDFC_EVT_UPPER_SAT  = 5;

    // which counter group an address selects
    typedef enum logic [1:0] {
        CDFC_SEL_UART  = 2'b00,
        CDFC_SEL_LOWER = 2'b01,
        CDFC_SEL_UPPER = 2'b10,
        CDFC_SEL_NONE  = 2'b11
    } cdfc_sel_t;

    // state of one discard counter
    typedef struct packed {
        logic [7:0] count;
    } cdfc_cnt_t;

    // state of the register file
    typedef struct packed {
        logic [7:0] rdata;
        logic [5:0] status;
        logic [5:0] mask;
        logic       irq;
    } cdfc_regs_t;

    // address to counter group, used by the snapshot strobes; the read mux decodes the same offsets itself
    function automatic cdfc_sel_t cdfc_decode(input logic [9:0] addr);
        cdfc_sel_t sel;
        sel = CDFC_SEL_NONE;
        case (addr)
            CDFC_UART_DROP_OFS:  sel = CDFC_SEL_UART;
            CDFC_LOWER_DROP_OFS: sel = CDFC_SEL_LOWER;
            CDFC_UPPER_DROP_OFS: sel = CDFC_SEL_UPPER;
            default:             sel = CDFC_SEL_NONE;
        endcase
        return sel;
    endfunction : cdfc_decode

endpackage : cdfc_pkg

/* logic/cdfc_drop_counter.sv */
// cdfc_drop_counter: one saturating discard counter of a port group
// assumes drop and frame_integrity_error come from logic on ref_clk

`timescale 1ns/1ns
`default_nettype none

module cdfc_drop_counter
    import cdfc_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic       drop,
    input  wire logic       frame_integrity_error,
    input  wire logic       snap,
    output logic      [7:0] count,
    output logic            counted,
    output logic            saturated
);

    cdfc_cnt_t st_ff;
    cdfc_cnt_t nxt_st;
    logic      bump;

    // ------------------------
    // event qualification
    // ------------------------
    // integrity rejects never count, only other discard causes
    assign bump      = drop & ~frame_integrity_error;
    assign counted   = bump;
    // flags the step onto the ceiling, once per interval
    assign saturated = bump & ~snap & (st_ff.count == CDFC_COUNT_NEAR);
    assign count     = st_ff.count;

    // ------------------------
    // next count
    // ------------------------
    // a discard in the snapshot cycle opens the new interval at one,
    // so no frame is lost between two reads
    always_comb begin
        nxt_st = st_ff;
        if (snap) begin
            nxt_st.count = bump ? CDFC_COUNT_ONE : CDFC_COUNT_RST;
        end else if (bump && (st_ff.count != CDFC_COUNT_MAX)) begin
            nxt_st.count = 8'(st_ff.count + CDFC_COUNT_ONE);
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_ff.count <= CDFC_COUNT_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule : cdfc_drop_counter

`default_nettype wire

/* logic/cdfc_top.sv */
// cdfc_top: discard frame statistics for the host uart and both chain ports
// assumes frame receivers on ref_clk pulse a drop line per discarded frame,
// with the integrity error line high in the same cycle when that caused it
//
// Summary of operation
// - An 8-bit counter of command frames discarded on the host uart, reset to zero.
// - An 8-bit counter of command frames discarded on the lower chain port, reset to zero.
// - An 8-bit counter of response frames discarded on the upper chain port, reset to zero.
// - Reading the uart drop count snapshots the whole uart group and clears its counters.
// - Reading the lower port drop count snapshots the lower group and clears its counters.
// - Reading the upper port drop count snapshots the upper group and clears its counters.
// - A frame rejected for a frame integrity error is never counted as a discard.

`timescale 1ns/1ns
`default_nettype none

module cdfc_top
    import cdfc_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,

    // register port
    input  wire logic [9:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,

    // host uart receiver
    input  wire logic       uart_cmd_drop,
    input  wire logic       uart_frame_integrity_error,

    // lower chain port receiver
    input  wire logic       lower_chain_port_cmd_drop,
    input  wire logic       lower_chain_port_frame_integrity_error,

    // upper chain port receiver
    input  wire logic       upper_chain_port_rsp_drop,
    input  wire logic       upper_chain_port_frame_integrity_error,

    // group snapshot strobes to the other statistics of each port
    output logic            uart_group_snap,
    output logic            lower_group_snap,
    output logic            upper_group_snap,

    // interrupt
    output logic            irq
);

    // ------------------------
    // declarations
    // ------------------------
    cdfc_regs_t st_ff;
    cdfc_regs_t nxt_st;

    cdfc_sel_t  rd_sel;

    logic [7:0] uart_count;
    logic [7:0] lower_count;
    logic [7:0] upper_count;

    logic       uart_counted;
    logic       lower_counted;
    logic       upper_counted;

    logic       uart_saturated;
    logic       lower_saturated;
    logic       upper_saturated;

    logic [5:0] evt_set;
    logic [5:0] evt_clr;

    logic       stat_wr;
    logic       mask_wr;

    // ------------------------
    // address decode
    // ------------------------
    // the snapshots use the shared decode of the same offsets that the read data mux selects
    assign rd_sel = reg_rd ? cdfc_decode(reg_addr) : CDFC_SEL_NONE;

    // mask is plain read/write, status is write one to clear, counters are read only
    assign stat_wr = reg_wr & (reg_addr == CDFC_IRQ_STAT_OFS);
    assign mask_wr = reg_wr & (reg_addr == CDFC_IRQ_MASK_OFS);

    // ------------------------
    // snapshot strobes
    // ------------------------
    // combinational so every statistic of a group latches on the same
    // edge as the counter read; a registered strobe would skew by one cycle
    assign uart_group_snap  = (rd_sel == CDFC_SEL_UART);
    assign lower_group_snap = (rd_sel == CDFC_SEL_LOWER);
    assign upper_group_snap = (rd_sel == CDFC_SEL_UPPER);

    // ------------------------
    // discard counters
    // ------------------------
    // host uart command discards
    cdfc_drop_counter u_uart_cnt (
        .ref_clk               (ref_clk),
        .sys_rst               (sys_rst),
        .drop                  (uart_cmd_drop),
        .frame_integrity_error (uart_frame_integrity_error),
        .snap                  (uart_group_snap),
        .count                 (uart_count),
        .counted               (uart_counted),
        .saturated             (uart_saturated)
    );

    // lower chain port command discards
    cdfc_drop_counter u_lower_cnt (
        .ref_clk               (ref_clk),
        .sys_rst               (sys_rst),
        .drop                  (lower_chain_port_cmd_drop),
        .frame_integrity_error (lower_chain_port_frame_integrity_error),
        .snap                  (lower_group_snap),
        .count                 (lower_count),
        .counted               (lower_counted),
        .saturated             (lower_saturated)
    );

    // upper chain port response discards
    cdfc_drop_counter u_upper_cnt (
        .ref_clk               (ref_clk),
        .sys_rst               (sys_rst),
        .drop                  (upper_chain_port_rsp_drop),
        .frame_integrity_error (upper_chain_port_frame_integrity_error),
        .snap                  (upper_group_snap),
        .count                 (upper_count),
        .counted               (upper_counted),
        .saturated             (upper_saturated)
    );

    // ------------------------
    // interrupt events
    // ------------------------
    // a counted discard and the step onto the ceiling are both reported;
    // the ceiling event tells software the interval count now holds at 8'hff and later discards go uncounted
    always_comb begin
        evt_set                      = CDFC_STAT_RST;
        evt_set[CDFC_EVT_UART_DROP]  = uart_counted;
        evt_set[CDFC_EVT_LOWER_DROP] = lower_counted;
        evt_set[CDFC_EVT_UPPER_DROP] = upper_counted;
        evt_set[CDFC_EVT_UART_SAT]   = uart_saturated;
        evt_set[CDFC_EVT_LOWER_SAT]  = lower_saturated;
        evt_set[CDFC_EVT_UPPER_SAT]  = upper_saturated;
    end

    // write one to clear, only on the status offset
    assign evt_clr = stat_wr ? reg_wdata[5:0] : CDFC_STAT_RST;

    // ------------------------
    // register file next state
    // ------------------------
    always_comb begin
        nxt_st = st_ff;

        // read data: the counter value at the read is the snapshot the
        // group closes with; unmapped offsets answer zero
        if (reg_rd) begin
            case (reg_addr)
                CDFC_UART_DROP_OFS:  nxt_st.rdata = uart_count;
                CDFC_LOWER_DROP_OFS: nxt_st.rdata = lower_count;
                CDFC_UPPER_DROP_OFS: nxt_st.rdata = upper_count;
                CDFC_IRQ_STAT_OFS:   nxt_st.rdata = {2'h0, st_ff.status};
                CDFC_IRQ_MASK_OFS:   nxt_st.rdata = {2'h0, st_ff.mask};
                default:             nxt_st.rdata = CDFC_RDATA_RST;
            endcase
        end

        // sticky status: an event in the clearing cycle survives the clear
        nxt_st.status = (st_ff.status & ~evt_clr) | evt_set;

        // mask follows software writes, upper data bits are dropped
        if (mask_wr) begin
            nxt_st.mask = reg_wdata[5:0];
        end

        // level interrupt while any unmasked status bit is set
        nxt_st.irq = |(nxt_st.status & nxt_st.mask);
    end

    // ------------------------
    // register file state
    // ------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_ff.rdata  <= CDFC_RDATA_RST;
            st_ff.status <= CDFC_STAT_RST;
            st_ff.mask   <= CDFC_MASK_RST;
            st_ff.irq    <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------
    // outputs
    // ------------------------
    // read data holds until the next read; writes to counters are ignored
    assign reg_rdata = st_ff.rdata;
    assign irq       = st_ff.irq;

endmodule : cdfc_top

`default_nettype wire

/* tb/cdfc_monitor.sv */
// cdfc_monitor: port assertions of the discard statistics block
// assumes one clock ref_clk and a synchronous active high sys_rst
`timescale 1ns/1ns
`default_nettype none
module cdfc_monitor
    import cdfc_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       sys_rst,
    input wire logic [9:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       uart_cmd_drop,
    input wire logic       uart_frame_integrity_error,
    input wire logic       lower_chain_port_cmd_drop,
    input wire logic       lower_chain_port_frame_integrity_error,
    input wire logic       upper_chain_port_rsp_drop,
    input wire logic       upper_chain_port_frame_integrity_error,
    input wire logic       uart_group_snap,
    input wire logic       lower_group_snap,
    input wire logic       upper_group_snap,
    input wire logic       irq
);
    // -----------------------------
    // reference counts
    // -----------------------------
    logic [7:0] ref_cnt [3];
    logic [2:0] hit;
    logic [2:0] rd_sel;
    // integrity errors never count, so they are masked out here
    assign hit = {upper_chain_port_rsp_drop & ~upper_chain_port_frame_integrity_error,
                  lower_chain_port_cmd_drop & ~lower_chain_port_frame_integrity_error,
                  uart_cmd_drop & ~uart_frame_integrity_error};
    assign rd_sel = {reg_rd && reg_addr == CDFC_UPPER_DROP_OFS,
                     reg_rd && reg_addr == CDFC_LOWER_DROP_OFS,
                     reg_rd && reg_addr == CDFC_UART_DROP_OFS};
    // a drop in the read cycle opens the new interval at one
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < 3; i++) begin
            if (sys_rst) ref_cnt[i] <= 8'h00;
            else if (rd_sel[i]) ref_cnt[i] <= {7'h00, hit[i]};
            else if (hit[i] && ref_cnt[i] != 8'hff) ref_cnt[i] <= ref_cnt[i] + 8'h01;
        end
    end
    // -----------------------------
    // assertions
    // -----------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_rd(logic [9:0] a);
        reg_rd && reg_addr == a;
    endsequence
    AST_UART_SNAP: assert property (uart_group_snap == rd_sel[0])
        else $error("uart snapshot strobe wrong");
    AST_LOWER_SNAP: assert property (lower_group_snap == rd_sel[1])
        else $error("lower snapshot strobe wrong");
    AST_UPPER_SNAP: assert property (upper_group_snap == rd_sel[2])
        else $error("upper snapshot strobe wrong");
    AST_UART_READ: assert property (s_rd(CDFC_UART_DROP_OFS) |=> reg_rdata == $past(ref_cnt[0]))
        else $error("uart drop count wrong");
    AST_LOWER_READ: assert property (s_rd(CDFC_LOWER_DROP_OFS) |=> reg_rdata == $past(ref_cnt[1]))
        else $error("lower drop count wrong");
    AST_UPPER_READ: assert property (s_rd(CDFC_UPPER_DROP_OFS) |=> reg_rdata == $past(ref_cnt[2]))
        else $error("upper drop count wrong");
    AST_UNMAPPED_READ: assert property (reg_rd && reg_addr > CDFC_IRQ_MASK_OFS |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
endmodule : cdfc_monitor
bind cdfc_top cdfc_monitor u_mon (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .uart_cmd_drop(uart_cmd_drop), .uart_frame_integrity_error(uart_frame_integrity_error),
    .lower_chain_port_cmd_drop(lower_chain_port_cmd_drop),
    .lower_chain_port_frame_integrity_error(lower_chain_port_frame_integrity_error),
    .upper_chain_port_rsp_drop(upper_chain_port_rsp_drop),
    .upper_chain_port_frame_integrity_error(upper_chain_port_frame_integrity_error),
    .uart_group_snap(uart_group_snap), .lower_group_snap(lower_group_snap),
    .upper_group_snap(upper_group_snap), .irq(irq));
`default_nettype wire

/* tb/cdfc_rx_model.sv */
// cdfc_rx_model: frame receivers that report discarded frames
// assumes the bench pulses go for one cycle with port, count and error held
`timescale 1ns/1ns
`default_nettype none
module cdfc_rx_model (
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic       go,
    input  wire logic [1:0] port,
    input  wire logic [8:0] n,
    input  wire logic       bad,
    output logic      [2:0] drop,
    output logic      [2:0] frame_integrity_error,
    output logic            busy
);
    logic [8:0] left;
    // one discard per cycle; idle error lines toggle so no stale level is trusted
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            left <= 9'h000;
            drop <= 3'h0;
            frame_integrity_error <= 3'h0;
        end else begin
            drop <= 3'h0;
            frame_integrity_error <= ~frame_integrity_error;
            if (go) left <= n;
            else if (left != 9'h000) begin
                drop[port] <= 1'b1;
                frame_integrity_error[port] <= bad;
                left <= left - 9'h001;
            end
        end
    end
    assign busy = (left != 9'h000) || (|drop);
endmodule : cdfc_rx_model
`default_nettype wire

/* tb/comm_discard_frame_counters_tb_top.sv */
// comm_discard_frame_counters_tb_top: register level tests of the discard counters
// assumes the receiver model feeds drop lines and the bench owns the register port
`timescale 1ns/1ns
`default_nettype none
module comm_discard_frame_counters_tb_top;
    logic       ref_clk, sys_rst, reg_wr, reg_rd, irq, go, bad, busy;
    logic [9:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [2:0] drop, frame_integrity_error;
    logic [1:0] port;
    logic [8:0] n;
    int         errors, tests_run;
    cdfc_top uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .uart_cmd_drop(drop[0]), .uart_frame_integrity_error(frame_integrity_error[0]),
        .lower_chain_port_cmd_drop(drop[1]),
        .lower_chain_port_frame_integrity_error(frame_integrity_error[1]),
        .upper_chain_port_rsp_drop(drop[2]),
        .upper_chain_port_frame_integrity_error(frame_integrity_error[2]),
        .uart_group_snap(), .lower_group_snap(), .upper_group_snap(), .irq(irq));
    cdfc_rx_model u_rx (.ref_clk(ref_clk), .sys_rst(sys_rst), .go(go), .port(port), .n(n),
        .bad(bad), .drop(drop), .frame_integrity_error(frame_integrity_error), .busy(busy));
    // -----------------------------
    // bus tasks
    // -----------------------------
    task check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task print_verdict;
        if (errors == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    task rd(input logic [9:0] a, input logic [7:0] exp);
        @(posedge ref_clk) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge ref_clk) reg_rd <= 1'b0;
        @(negedge ref_clk) check(reg_rdata, exp);
    endtask : rd
    task wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge ref_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge ref_clk) reg_wr <= 1'b0;
    endtask : wr
    task irq_is(input logic exp);
        @(negedge ref_clk) check({7'h00, irq}, {7'h00, exp});
    endtask : irq_is
    // bounded wait: a receiver that never finishes ends the run
    task send(input logic [1:0] p, input logic [8:0] cnt, input logic b);
        @(posedge ref_clk) {go, port, n, bad} <= {1'b1, p, cnt, b};
        @(posedge ref_clk) go <= 1'b0;
        for (int k = 0; k <= 600; k++) begin
            @(negedge ref_clk);
            if (!busy) break;
            if (k == 600) begin
                errors++;
                print_verdict();
            end
        end
    endtask : send
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // -----------------------------
    // main sequence
    // -----------------------------
    initial begin
        {sys_rst, reg_wr, reg_rd, go, bad, port, n} = {1'b1, 15'h0000};
        {reg_addr, reg_wdata, errors, tests_run} = '0;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (int p = 0; p < 3; p++) rd(10'h265 + 10'(p), 8'h00);
        rd(10'h300, 8'h00);
        // good and integrity-failed drops, a write that must not land, then the clearing read
        for (int p = 0; p < 3; p++) begin
            send(2'(p), 9'h003, 1'b0);
            send(2'(p), 9'h002, 1'b1);
            wr(10'h265 + 10'(p), 8'h55);
            rd(10'h265 + 10'(p), 8'h03);
            rd(10'h265 + 10'(p), 8'h00);
        end
        send(2'h0, 9'h12c, 1'b0);
        rd(10'h265, 8'hff);
        // interrupt raised, read, masked and cleared
        wr(10'h271, 8'h01);
        wr(10'h270, 8'h3f);
        irq_is(1'b0);
        send(2'h0, 9'h001, 1'b0);
        irq_is(1'b1);
        rd(10'h270, 8'h01);
        wr(10'h271, 8'h00);
        irq_is(1'b0);
        wr(10'h270, 8'h01);
        rd(10'h270, 8'h00);
        print_verdict();
    end
endmodule : comm_discard_frame_counters_tb_top
`default_nettype wire
